// ===== nvsram_spi_pkg.sv
// Constants shared by the serial nonvolatile SRAM command block
package nvsram_spi_pkg;

  // Opcodes
  localparam logic [7:0] OP_SET_WL  = 8'h06;
  localparam logic [7:0] OP_CLR_WL  = 8'h04;
  localparam logic [7:0] OP_SR_RD   = 8'h05;
  localparam logic [7:0] OP_SR_WR   = 8'h01;
  localparam logic [7:0] OP_ARR_RD  = 8'h03;
  localparam logic [7:0] OP_ARR_WR  = 8'h02;
  localparam logic [7:0] OP_CLK_RD  = 8'h13;
  localparam logic [7:0] OP_CLK_WR  = 8'h12;
  localparam logic [7:0] OP_STORE   = 8'h3c;
  localparam logic [7:0] OP_RECALL  = 8'h60;
  localparam logic [7:0] OP_AS_ON   = 8'h59;
  localparam logic [7:0] OP_AS_OFF  = 8'h19;

  // Status byte layout
  localparam int SR_BUSY_BIT  = 0;
  localparam int SR_WEL_BIT   = 1;
  localparam int SR_BG_LO_BIT = 2;
  localparam int SR_BG_HI_BIT = 3;
  localparam int SR_GUARD_BIT = 7;

  // Values after reset
  localparam logic       WEL_RST       = 1'b0;
  localparam logic       GUARD_RST     = 1'b0;
  localparam logic [1:0] BLOCK_RST     = 2'b00;
  localparam logic       AUTO_SAVE_RST = 1'b1;
  localparam logic [7:0] CLK_REG_RST   = 8'h00;

  // Array and block guard
  localparam int         ARR_ADDR_W    = 16;
  localparam int         ARR_ADDR_BYTES = 2;
  localparam logic [1:0] GUARD_NONE    = 2'b00;
  localparam logic [1:0] GUARD_QUARTER = 2'b01;
  localparam logic [1:0] GUARD_HALF    = 2'b10;
  localparam logic [15:0] QUARTER_BASE = 16'hc000;
  localparam logic [15:0] HALF_BASE    = 16'h8000;

  // Clock register space
  localparam int         CLK_REG_CNT   = 16;
  localparam int         CLK_IDX_W     = 4;
  localparam logic [3:0] CLK_FLAGS_IDX = 4'h0;
  localparam int         FLAG_FREEZE_BIT = 0;
  localparam int         FLAG_HOLD_BIT   = 1;

  // Read data pipeline depth from address to load
  localparam int         RD_LAT = 2;

  // Write buffer entry width: address plus data
  localparam int         WBUF_W = ARR_ADDR_W + 8;

  typedef enum logic [8:0] {
    ST_IDLE   = 9'b000000001,
    ST_ADDR   = 9'b000000010,
    ST_SR_RD  = 9'b000000100,
    ST_SR_WR  = 9'b000001000,
    ST_ARR_RD = 9'b000010000,
    ST_ARR_WR = 9'b000100000,
    ST_CLK_RD = 9'b001000000,
    ST_CLK_WR = 9'b010000000,
    ST_IGNORE = 9'b100000000
  } st_e;

endpackage

// ===== wr_pair_buffer.sv
// Two-entry valid/ready buffer in the array write path
`timescale 1ns/1ps
`default_nettype none

module wr_pair_buffer #(
  parameter int WIDTH = 24,
  parameter int DEPTH = 2
) (
  input  wire logic             clk_i,
  input  wire logic             sys_rst_i,
  input  wire logic             in_valid_i,
  output logic                  in_ready_o,
  input  wire logic [WIDTH-1:0] in_data_i,
  output logic                  out_valid_o,
  input  wire logic             out_ready_i,
  output logic      [WIDTH-1:0] out_data_o
);

  localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

  logic [WIDTH-1:0] mem [DEPTH];
  logic [PW-1:0]    wr_ptr;
  logic [PW-1:0]    rd_ptr;
  logic [PW:0]      count;
  logic             push;
  logic             pop;

  assign in_ready_o  = (count != (PW+1)'(DEPTH));
  assign out_valid_o = (count != '0);
  assign out_data_o  = mem[rd_ptr];
  assign push        = in_valid_i && in_ready_o;
  assign pop         = out_valid_o && out_ready_i;

  function automatic logic [PW-1:0] bump(input logic [PW-1:0] p);
    bump = (p == (PW)'(DEPTH - 1)) ? '0 : p + 1'b1;
  endfunction

  always_ff @(posedge clk_i) begin
    if (push) begin
      mem[wr_ptr] <= in_data_i;
    end
  end

  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count  <= '0;
    end else begin
      if (push) begin
        wr_ptr <= bump(wr_ptr);
      end
      if (pop) begin
        rd_ptr <= bump(rd_ptr);
      end
      count <= count + (PW+1)'(push) - (PW+1)'(pop);
    end
  end

endmodule

`default_nettype wire

// ===== spi_nvsram_write_protect_access.sv
// Serial command block: write latch, protection, array and clock access
//
// Operation
// RULE_01 - Write-class commands run only while the write latch is set.
// RULE_02 - Write latch is clear after reset.
// RULE_03 - Write-class command with latch clear is ignored until next frame.
// RULE_04 - Set-latch command sets the write latch.
// RULE_05 - Any completed write-class command clears the write latch.
// RULE_06 - Clear-latch command clears the latch when chip select rises.
// RULE_07 - Block guard bits protect none, upper quarter, upper half or all.
// RULE_08 - Protect pin low with pin guard set blocks status writes.
// RULE_09 - Pin guard clear makes the protect pin irrelevant.
// RULE_10 - Protect pin falling mid-frame does not affect a status write.
// RULE_11 - Array access refused during store or recall; busy bit and pin show it.
// RULE_12 - Read: opcode, two address bytes, data out on falling edges MSB first.
// RULE_13 - Serial input ignored after last read address bit.
// RULE_14 - Read address increments and wraps from top to zero.
// RULE_15 - Master ends a single read after one data byte.
// RULE_16 - Write: opcode, two address bytes, data stored at rising addresses.
// RULE_17 - Burst write wraps from top to zero; single byte ends after LSB.
// RULE_18 - Protected bytes discarded but address still increments.
// RULE_19 - Sixteen clock registers, single or burst read and write.
// RULE_20 - Master sets the freeze flag before reading time registers.
// RULE_21 - Clock register writes except flags need the hold flag set.
// RULE_22 - Clearing the hold flag loads the new time into the counters.
// RULE_23 - Status write changes only pin guard and block guard bits.
// RULE_24 - Busy bit reads one during store or recall.
// RULE_25 - Clock register address wraps to zero after the last one.
// RULE_26 - Input sampled on rising clock, idle low or high, MSB first.
`timescale 1ns/1ps
`default_nettype none

module spi_nvsram_write_protect_access (
  input  wire logic                                  clk_i,
  input  wire logic                                  sys_rst_i,
  input  wire logic                                  sclk_i,
  input  wire logic                                  cs_n_i,
  input  wire logic                                  mosi_i,
  output logic                                       miso_o,
  output logic                                       miso_oe_o,
  input  wire logic                                  protect_n_i,
  input  wire logic                                  nv_busy_i,
  output logic                                       store_busy_pin_n_o,
  output logic                                       store_req_o,
  output logic                                       recall_req_o,
  output logic                                       auto_save_on_o,
  output logic                                       write_latch_o,
  output logic                                       pin_guard_enable_o,
  output logic                                       block_guard_hi_o,
  output logic                                       block_guard_lo_o,
  output logic                                       freeze_o,
  output logic                                       time_load_o,
  output logic                                       write_drop_o,
  output logic [nvsram_spi_pkg::ARR_ADDR_W-1:0]      mem_raddr_o,
  input  wire logic [7:0]                            mem_rdata_i,
  output logic                                       mem_wr_valid_o,
  input  wire logic                                  mem_wr_ready_i,
  output logic [nvsram_spi_pkg::ARR_ADDR_W-1:0]      mem_waddr_o,
  output logic [7:0]                                 mem_wdata_o
);
  import nvsram_spi_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers; edges looked at only past the first stage
  logic [2:0] sclk_q;
  logic [2:0] cs_q;
  logic [1:0] mosi_q;
  logic       sclk_rise;
  logic       sclk_fall;
  logic       cs_rise;
  logic       active;
  logic       prot_n_q1;
  logic       prot_n_s;

  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      sclk_q    <= 3'h0;
      cs_q      <= 3'h7;
      mosi_q    <= 2'h0;
      prot_n_q1 <= 1'b1;
      prot_n_s  <= 1'b1;
    end else begin
      sclk_q    <= {sclk_q[1:0], sclk_i};
      cs_q      <= {cs_q[1:0], cs_n_i};
      mosi_q    <= {mosi_q[0], mosi_i};
      prot_n_q1 <= protect_n_i;
      prot_n_s  <= prot_n_q1;
    end
  end

  assign active    = ~cs_q[1];
  assign sclk_rise = sclk_q[1] & ~sclk_q[2];
  assign sclk_fall = ~sclk_q[1] & sclk_q[2];
  assign cs_rise   = cs_q[1] & ~cs_q[2];

  ////////////////////////////////////////////////////////////////////////////
  // Bit and byte assembly
  logic [2:0] bit_cnt;
  logic [6:0] shift_in;
  logic       byte_done;
  logic [7:0] byte_val;

  assign byte_done = sclk_rise && active && (bit_cnt == 3'h7);
  assign byte_val  = {shift_in, mosi_q[1]};

  // RULE_26 rising edge sampling
  always_ff @(posedge clk_i) begin
    if (sys_rst_i || !active) begin
      bit_cnt  <= 3'h0;
      shift_in <= 7'h00;
    end else if (sclk_rise) begin
      bit_cnt  <= bit_cnt + 3'h1;
      shift_in <= byte_val[6:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Protection helpers
  logic       wel;
  logic       pin_guard;
  logic [1:0] block_guard;
  logic       busy;

  // RULE_07 guard level decode
  function automatic logic is_guarded(input logic [1:0] lvl, input logic [15:0] a);
    case (lvl)
      GUARD_NONE:    is_guarded = 1'b0;
      GUARD_QUARTER: is_guarded = (a >= QUARTER_BASE);
      GUARD_HALF:    is_guarded = (a >= HALF_BASE);
      default:       is_guarded = 1'b1;
    endcase
  endfunction

  function automatic logic is_write_class(input logic [7:0] op);
    is_write_class = (op == OP_SR_WR) || (op == OP_ARR_WR) || (op == OP_CLK_WR) ||
                     (op == OP_STORE) || (op == OP_RECALL) || (op == OP_AS_ON) ||
                     (op == OP_AS_OFF);
  endfunction

  assign busy = nv_busy_i;

  ////////////////////////////////////////////////////////////////////////////
  // Command state machine
  st_e        state;
  logic [7:0] cmd;
  logic       addr_cnt;
  logic       cmd_ok;

  // RULE_01 latch gates write class
  // RULE_11 array refused while busy
  assign cmd_ok = (!is_write_class(byte_val) || wel) &&
                  (!((byte_val == OP_ARR_RD) || (byte_val == OP_ARR_WR)) || !busy);

  always_ff @(posedge clk_i) begin
    if (sys_rst_i || !active) begin
      state    <= ST_IDLE;
      cmd      <= 8'h00;
      addr_cnt <= 1'b0;
    end else if (byte_done) begin
      case (state)
        ST_IDLE: begin
          cmd      <= byte_val;
          addr_cnt <= 1'b0;
          // RULE_03 refused command idles to frame end
          if (!cmd_ok) begin
            state <= ST_IGNORE;
          end else begin
            case (byte_val)
              OP_SR_RD:  state <= ST_SR_RD;
              OP_SR_WR:  state <= ST_SR_WR;
              OP_ARR_RD: state <= ST_ADDR;
              OP_ARR_WR: state <= ST_ADDR;
              OP_CLK_RD: state <= ST_ADDR;
              OP_CLK_WR: state <= ST_ADDR;
              default:   state <= ST_IGNORE;
            endcase
          end
        end
        ST_ADDR: begin
          addr_cnt <= 1'b1;
          if (addr_cnt || (cmd == OP_CLK_RD) || (cmd == OP_CLK_WR)) begin
            case (cmd)
              OP_ARR_RD: state <= ST_ARR_RD;
              OP_ARR_WR: state <= ST_ARR_WR;
              OP_CLK_RD: state <= ST_CLK_RD;
              OP_CLK_WR: state <= ST_CLK_WR;
              default:   state <= ST_IGNORE;
            endcase
          end
        end
        // Status write takes one byte; the rest of the frame is dropped
        ST_SR_WR: state <= ST_IGNORE;
        ST_SR_RD, ST_ARR_RD, ST_ARR_WR, ST_CLK_RD, ST_CLK_WR, ST_IGNORE: state <= state;
        default:  state <= ST_IGNORE;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Frame flags: latch clear and special commands act at chip select rise
  logic       wr_taken;
  logic       clr_pend;
  logic [7:0] spec_op;

  always_ff @(posedge clk_i) begin
    if (sys_rst_i || !active) begin
      wr_taken <= 1'b0;
      clr_pend <= 1'b0;
      spec_op  <= 8'h00;
    end else if (byte_done && state == ST_IDLE && cmd_ok) begin
      wr_taken <= is_write_class(byte_val);
      clr_pend <= (byte_val == OP_CLR_WL);
      spec_op  <= byte_val;
    end
  end

  always_ff @(posedge clk_i) begin
    // RULE_02 disabled after reset
    if (sys_rst_i) begin
      wel <= WEL_RST;
    // RULE_05 cleared on completion
    // RULE_06 cleared at chip select rise
    end else if (cs_rise && (wr_taken || clr_pend)) begin
      wel <= 1'b0;
    // RULE_04 set latch
    end else if (byte_done && state == ST_IDLE && byte_val == OP_SET_WL) begin
      wel <= 1'b1;
    end
  end

  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      store_req_o    <= 1'b0;
      recall_req_o   <= 1'b0;
      auto_save_on_o <= AUTO_SAVE_RST;
    end else begin
      store_req_o  <= cs_rise && wr_taken && (spec_op == OP_STORE);
      recall_req_o <= cs_rise && wr_taken && (spec_op == OP_RECALL);
      if (cs_rise && wr_taken && spec_op == OP_AS_ON) begin
        auto_save_on_o <= 1'b1;
      end else if (cs_rise && wr_taken && spec_op == OP_AS_OFF) begin
        auto_save_on_o <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Status register
  logic sr_locked;

  // RULE_10 pin state frozen at command decode
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      sr_locked <= 1'b0;
    end else if (byte_done && state == ST_IDLE) begin
      // RULE_08 pin low with guard blocks
      // RULE_09 guard clear ignores pin
      sr_locked <= pin_guard && !prot_n_s;
    end
  end

  // RULE_23 only guard bits change
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      pin_guard   <= GUARD_RST;
      block_guard <= BLOCK_RST;
    end else if (byte_done && state == ST_SR_WR && !sr_locked) begin
      pin_guard   <= byte_val[SR_GUARD_BIT];
      block_guard <= {byte_val[SR_BG_HI_BIT], byte_val[SR_BG_LO_BIT]};
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Array and clock register addressing
  logic [15:0]          arr_addr;
  logic [CLK_IDX_W-1:0] clk_idx;

  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      arr_addr <= 16'h0000;
      clk_idx  <= '0;
    end else if (byte_done) begin
      if (state == ST_ADDR) begin
        arr_addr <= {arr_addr[7:0], byte_val};
        clk_idx  <= byte_val[CLK_IDX_W-1:0];
      // RULE_14 read wraps naturally at top
      // RULE_17 write wraps naturally at top
      end else if (state == ST_ARR_RD || state == ST_ARR_WR) begin
        arr_addr <= arr_addr + 16'h0001;
      // RULE_25 register index wraps
      end else if (state == ST_CLK_RD || state == ST_CLK_WR) begin
        clk_idx <= clk_idx + 4'h1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Array write path through the two-entry buffer
  logic wb_valid;
  logic wb_ready;

  // RULE_16 data byte to current address
  // RULE_18 guarded bytes discarded
  assign wb_valid = byte_done && (state == ST_ARR_WR) && !is_guarded(block_guard, arr_addr);

  // Serial link cannot stall, so a full buffer can only report the loss
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      write_drop_o <= 1'b0;
    end else begin
      write_drop_o <= wb_valid && !wb_ready;
    end
  end

  wr_pair_buffer #(
    .WIDTH (WBUF_W),
    .DEPTH (2)
  ) u_wbuf (
    .clk_i       (clk_i),
    .sys_rst_i   (sys_rst_i),
    .in_valid_i  (wb_valid),
    .in_ready_o  (wb_ready),
    .in_data_i   ({arr_addr, byte_val}),
    .out_valid_o (mem_wr_valid_o),
    .out_ready_i (mem_wr_ready_i),
    .out_data_o  ({mem_waddr_o, mem_wdata_o})
  );

  ////////////////////////////////////////////////////////////////////////////
  // Clock register space
  logic [7:0] clk_regs [CLK_REG_CNT];
  logic       hold_q;
  logic       hold_now;

  assign hold_now = clk_regs[CLK_FLAGS_IDX][FLAG_HOLD_BIT];

  // RULE_19 sixteen registers
  // RULE_21 hold flag gates non-flag writes
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      for (int i = 0; i < CLK_REG_CNT; i++) begin
        clk_regs[i] <= CLK_REG_RST;
      end
    end else if (byte_done && state == ST_CLK_WR &&
                 (clk_idx == CLK_FLAGS_IDX || hold_now)) begin
      clk_regs[clk_idx] <= byte_val;
    end
  end

  // RULE_22 load pulse on hold release
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      hold_q      <= 1'b0;
      time_load_o <= 1'b0;
    end else begin
      hold_q      <= hold_now;
      time_load_o <= hold_q && !hold_now;
    end
  end

  // RULE_20 freeze flag shown to the counters
  assign freeze_o = clk_regs[CLK_FLAGS_IDX][FLAG_FREEZE_BIT];

  ////////////////////////////////////////////////////////////////////////////
  // Serial output
  logic [RD_LAT-1:0] load_pipe;
  logic [7:0]        tx_shift;
  logic [7:0]        sr_byte;
  logic              rd_state;
  logic              load_now;

  assign rd_state = (state == ST_SR_RD) || (state == ST_ARR_RD) || (state == ST_CLK_RD);
  // RULE_24 busy bit
  assign sr_byte  = {pin_guard, 3'b000, block_guard, wel, busy};
  // Next byte fetched on the status read opcode, on the last address byte or on each finished read byte
  assign load_now = byte_done && ((state == ST_IDLE && cmd_ok && byte_val == OP_SR_RD) ||
                    (state == ST_ADDR && (addr_cnt || cmd == OP_CLK_RD) &&
                     (cmd == OP_ARR_RD || cmd == OP_CLK_RD)) || rd_state);

  always_ff @(posedge clk_i) begin
    if (sys_rst_i || !active) begin
      load_pipe <= '0;
    end else begin
      load_pipe <= {load_pipe[RD_LAT-2:0], load_now};
    end
  end

  // RULE_12 falling edge, MSB first
  // RULE_13 input ignored during read data
  always_ff @(posedge clk_i) begin
    if (sys_rst_i || !active) begin
      tx_shift <= 8'h00;
      miso_o   <= 1'b0;
    end else if (load_pipe[RD_LAT-1]) begin
      case (state)
        ST_ARR_RD: tx_shift <= mem_rdata_i;
        ST_CLK_RD: tx_shift <= clk_regs[clk_idx];
        default:   tx_shift <= sr_byte;
      endcase
    end else if (sclk_fall && rd_state) begin
      miso_o   <= tx_shift[7];
      tx_shift <= {tx_shift[6:0], 1'b0};
    end
  end

  assign miso_oe_o          = active && rd_state;
  assign mem_raddr_o        = arr_addr;
  assign write_latch_o      = wel;
  assign pin_guard_enable_o = pin_guard;
  assign block_guard_hi_o   = block_guard[1];
  assign block_guard_lo_o   = block_guard[0];

  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      store_busy_pin_n_o <= 1'b1;
    end else begin
      store_busy_pin_n_o <= ~busy;
    end
  end

endmodule

`default_nettype wire

// ===== spi_master_model.sv
// Serial bus master model that frames commands for the nvSRAM block
`timescale 1ns/1ps
`default_nettype none
module spi_master_model (
  output logic      sclk_o,
  output logic      cs_n_o,
  output logic      mosi_o,
  input  wire logic miso_i
);
  initial begin
    sclk_o = 1'b0;
    cs_n_o = 1'b1;
    mosi_o = 1'b0;
  end
  ////////////////////////////////////////////////////////////////////////////
  // Clock idles low, stands still outside frames
  task automatic start();
    cs_n_o = 1'b0;
    #40;
  endtask
  task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
    for (int i = 7; i >= 0; i--) begin
      mosi_o = tx[i];
      #40 sclk_o = 1'b1;
      rx[i] = miso_i;
      #40 sclk_o = 1'b0;
    end
  endtask
  // Released input flips, so no stale bit is reused
  task automatic stop();
    #40 cs_n_o = 1'b1;
    mosi_o = ~mosi_o;
    #40;
  endtask
endmodule
`default_nettype wire

// ===== nvsram_chk.sv
// Assertion checker for the serial nvSRAM command block
`timescale 1ns/1ps
`default_nettype none
module nvsram_chk (
  input wire logic        clk_i,
  input wire logic        sys_rst_i,
  input wire logic        cs_n_i,
  input wire logic        nv_busy_i,
  input wire logic        store_busy_pin_n_o,
  input wire logic        miso_oe_o,
  input wire logic        store_req_o,
  input wire logic        auto_save_on_o,
  input wire logic        write_latch_o,
  input wire logic        pin_guard_enable_o,
  input wire logic        block_guard_hi_o,
  input wire logic        block_guard_lo_o,
  input wire logic        time_load_o,
  input wire logic        write_drop_o,
  input wire logic        mem_wr_valid_o,
  input wire logic        mem_wr_ready_i,
  input wire logic [15:0] mem_waddr_o,
  input wire logic [7:0]  mem_wdata_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (sys_rst_i);
  ////////////////////////////////////////////////////////////////////////////
  chk_busy_pin: assert property (
    $past(!sys_rst_i) |-> store_busy_pin_n_o == !$past(nv_busy_i))
    else $error("busy pin does not follow the store cycle");
  chk_oe_idle: assert property (
    cs_n_i [*6] |-> !miso_oe_o)
    else $error("output driven while deselected");
  chk_store_pulse: assert property (
    store_req_o |=> !store_req_o)
    else $error("store request longer than one cycle");
  chk_latch_set: assert property (
    $rose(write_latch_o) |-> !cs_n_i)
    else $error("latch set outside a frame");
  chk_latch_clear: assert property (
    $fell(write_latch_o) |-> cs_n_i && $past(cs_n_i))
    else $error("latch cleared before frame end");
  chk_guard_write: assert property (
    !$stable({pin_guard_enable_o, block_guard_hi_o, block_guard_lo_o}) |-> $past(write_latch_o))
    else $error("guard bits changed without latch");
  chk_save_write: assert property (
    $changed(auto_save_on_o) |-> $past(write_latch_o))
    else $error("auto save changed without latch");
  chk_time_load: assert property (
    time_load_o |-> $past(write_latch_o) ##1 !time_load_o)
    else $error("bad time load pulse");
  chk_drop_full: assert property (
    write_drop_o |-> mem_wr_valid_o)
    else $error("byte dropped while buffer had room");
  chk_wr_hold: assert property (
    mem_wr_valid_o && !mem_wr_ready_i |=>
      mem_wr_valid_o && $stable(mem_waddr_o) && $stable(mem_wdata_o))
    else $error("stalled write not held");
endmodule
bind spi_nvsram_write_protect_access nvsram_chk nvsram_chk_i (.*);
`default_nettype wire

// ===== testbench.sv
// Self-checking bench for the serial nvSRAM command block
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import nvsram_spi_pkg::*;
  logic        clk = 1'b0;
  logic        rst, sclk, cs_n, mosi, miso, miso_oe, miso_w, miso_last = 1'b0;
  logic        prot_n, busy, busy_pin_n, st_req, rc_req, as_on, wl;
  logic        pg, bh, bl, frz, tl, drop, wv, wr;
  logic [15:0] raddr, waddr;
  logic [7:0]  rdata, wdata, gd;
  logic [7:0]  rxq[$];
  logic [23:0] wq[$];
  int          np[4] = '{default: 0};
  int          n_fail = 0;
  int          n_checks = 0;

  always #2 clk = ~clk;
  assign miso_w = miso_oe ? miso : ~miso_last;
  assign rdata = raddr[7:0] + raddr[15:8] + 8'h01;
  assign gd = {5'h00, pg, bh, bl};
  always @(posedge clk) begin
    if (miso_oe) miso_last <= miso;
    if (wv && wr) wq.push_back({waddr, wdata});
    np[0] += st_req;
    np[1] += rc_req;
    np[2] += tl;
    np[3] += drop;
  end
  spi_nvsram_write_protect_access spi_nvsram_write_protect_access_i (
    .clk_i(clk), .sys_rst_i(rst), .sclk_i(sclk), .cs_n_i(cs_n), .mosi_i(mosi),
    .miso_o(miso), .miso_oe_o(miso_oe), .protect_n_i(prot_n), .nv_busy_i(busy),
    .store_busy_pin_n_o(busy_pin_n), .store_req_o(st_req), .recall_req_o(rc_req),
    .auto_save_on_o(as_on), .write_latch_o(wl), .pin_guard_enable_o(pg),
    .block_guard_hi_o(bh), .block_guard_lo_o(bl), .freeze_o(frz), .time_load_o(tl),
    .write_drop_o(drop), .mem_raddr_o(raddr), .mem_rdata_i(rdata),
    .mem_wr_valid_o(wv), .mem_wr_ready_i(wr), .mem_waddr_o(waddr), .mem_wdata_o(wdata));
  spi_master_model spi_master_model_i (
    .sclk_o(sclk), .cs_n_o(cs_n), .mosi_o(mosi), .miso_i(miso_w));
  ////////////////////////////////////////////////////////////////////////////
  task automatic stop_test();
    $display("checks %0d mismatches %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic frame(input logic [7:0] q[$]);
    logic [7:0] r;
    rxq = {};
    spi_master_model_i.start();
    foreach (q[k]) begin
      spi_master_model_i.xfer(q[k], r);
      rxq.push_back(r);
    end
    spi_master_model_i.stop();
  endtask
  task automatic wcmd(input logic [7:0] q[$]);
    frame({OP_SET_WL});
    frame(q);
  endtask
  task automatic wsr(input logic [7:0] v);
    wcmd({OP_SR_WR, v});
  endtask
  ////////////////////////////////////////////////////////////////////////////
  task automatic t_latch();
    chk(8'(wl), 8'h00);
    chk(gd, 8'h00);
    chk(8'(as_on), 8'h01);
    frame({OP_SR_WR, 8'h8c});
    chk(gd, 8'h00);
    frame({OP_SET_WL});
    chk(8'(wl), 8'h01);
    frame({OP_CLR_WL});
    chk(8'(wl), 8'h00);
  endtask
  task automatic t_status();
    logic [7:0] r;
    wsr(8'hff);
    chk(8'(wl), 8'h00);
    frame({OP_SR_RD, 8'h00});
    chk(rxq[1], 8'h8c);
    prot_n = 1'b0;
    wsr(8'h00);
    chk(gd, 8'h07);
    prot_n = 1'b1;
    wsr(8'h00);
    chk(gd, 8'h00);
    prot_n = 1'b0;
    wsr(8'h04);
    chk(gd, 8'h01);
    prot_n = 1'b1;
    wsr(8'h88);
    frame({OP_SET_WL});
    spi_master_model_i.start();
    spi_master_model_i.xfer(OP_SR_WR, r);
    prot_n = 1'b0;
    spi_master_model_i.xfer(8'h84, r);
    spi_master_model_i.stop();
    chk(gd, 8'h05);
    prot_n = 1'b1;
  endtask
  task automatic t_write();
    for (int g = 0; g < 4; g++) begin
      wsr(8'(g << 2));
      wq = {};
      wcmd({OP_ARR_WR, 8'hbf, 8'hff, 8'h5a, 8'ha5});
      chk(8'(wq.size()), 8'(g == 0 ? 2 : (g == 1 ? 1 : 0)));
    end
    wsr(8'h04);
    wq = {};
    wcmd({OP_ARR_WR, 8'hff, 8'hff, 8'h33, 8'h44});
    chk(8'(wq.size()), 8'h01);
    chk(wq[0][23:16] | wq[0][15:8], 8'h00);
    chk(wq[0][7:0], 8'h44);
    chk(8'(wl), 8'h00);
  endtask
  task automatic t_buf();
    int s;
    int i;
    wsr(8'h00);
    wq = {};
    wr = 1'b0;
    s = np[3];
    wcmd({OP_ARR_WR, 8'h12, 8'h30, 8'h0a, 8'h0b, 8'h0c});
    chk(8'(np[3] - s), 8'h01);
    wr = 1'b1;
    for (i = 0; i < 20 && wq.size() < 2; i++) @(negedge clk);
    if (i == 20) begin
      n_fail++;
      stop_test();
    end
    @(negedge clk);
    chk(8'(wv), 8'h00);
    chk(wq[1][15:8], 8'h31);
    chk(wq[1][7:0], 8'h0b);
  endtask
  task automatic t_read_busy();
    frame({OP_ARR_RD, 8'hff, 8'hff, 8'hff, 8'hff});
    chk(rxq[3], 8'hff);
    chk(rxq[4], 8'h01);
    busy = 1'b1;
    repeat (2) @(negedge clk);
    chk(8'(busy_pin_n), 8'h00);
    frame({OP_SR_RD, 8'h00});
    chk(8'(rxq[1][0]), 8'h01);
    wq = {};
    wcmd({OP_ARR_WR, 8'h00, 8'h00, 8'h77});
    chk(8'(wq.size()), 8'h00);
    busy = 1'b0;
  endtask
  task automatic t_clock();
    int s;
    wcmd({OP_CLK_WR, 8'h00, 8'h03});
    chk(8'(frz), 8'h01);
    wcmd({OP_CLK_WR, 8'h0f, 8'h5a, 8'h03});
    frame({OP_CLK_RD, 8'h0f, 8'h00, 8'h00});
    chk(rxq[2], 8'h5a);
    chk(rxq[3], 8'h03);
    s = np[2];
    wcmd({OP_CLK_WR, 8'h00, 8'h00});
    chk(8'(np[2] - s), 8'h01);
    wcmd({OP_CLK_WR, 8'h0f, 8'ha5});
    frame({OP_CLK_RD, 8'h0f, 8'h00});
    chk(rxq[2], 8'h5a);
  endtask
  task automatic t_special();
    int s;
    s = np[0];
    frame({OP_STORE});
    chk(8'(np[0] - s), 8'h00);
    wcmd({OP_STORE});
    chk(8'(np[0] - s), 8'h01);
    chk(8'(wl), 8'h00);
    s = np[1];
    wcmd({OP_RECALL});
    chk(8'(np[1] - s), 8'h01);
    wcmd({OP_AS_OFF});
    chk(8'(as_on), 8'h00);
    wcmd({OP_AS_ON});
    chk(8'(as_on), 8'h01);
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    rst = 1'b1;
    prot_n = 1'b1;
    busy = 1'b0;
    wr = 1'b1;
    repeat (2) @(negedge clk);
    rst = 1'b0;
    repeat (4) @(negedge clk);
    t_latch();
    t_status();
    t_write();
    t_buf();
    t_read_busy();
    t_clock();
    t_special();
    stop_test();
  end
endmodule
`default_nettype wire
